/* File: logic/tc_flag_bit.sv */
/*
 * One sticky match flag: set by a match pulse, cleared by vector
 * acknowledge or a written one. Set wins over a clear in the same cycle.
 */
`timescale 1ns/1ps
module tc_flag_bit (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic set,
    input  wire logic clear,
    output logic      flag
);
    typedef struct packed {
        logic flag;
    } flag_state_t;

    flag_state_t state_reg;
    flag_state_t state_next;

    // Set has priority so an event is never lost to a clear
    always_comb begin
        state_next = state_reg;
        if (set) begin
            state_next.flag = 1'b1;
        end else if (clear) begin
            state_next.flag = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign flag = state_reg.flag;
endmodule // tc_flag_bit

/* File: logic/tc_limited_core.sv */
/*
 * Counter and compare register part of a reduced 16-bit timer/counter that
 * drives no pins. Byte registers on an internal port with a shared high-byte
 * latch, three compare channels, match flags and a channel C force strobe.
 * Assumes the caller gives a timer clock tick and the waveform mode, and
 * that every register access lasts one mclk cycle.
 */
// Notes on behaviour
// - Force strobe honoured only in non-PWM modes
// - Force one acts as immediate channel C match
// - Forced match drives no output pin
// - Strobe is one cycle; output mode decides effect
// - Forced match: no interrupt, no counter clear
// - Force bit always reads as zero
// - Control bits 4 to 0 reserved, no function
// - Counter readable and writable as two bytes
// - Counter bytes pass through a high-byte latch
// - One latch shared by all 16-bit registers
// - Counter write blocks matches for next tick
// - Three compare values checked every tick
// - Match is the channel's interrupt source
// - Compare value commits both bytes together
// - Flag set cycle after match; cleared by ack/one
// - Normal and clear-on-compare are non-PWM modes
`timescale 1ns/1ps
module tc_limited_core #(
    parameter int WIDTH = 16
) (
    input  wire logic                           mclk,
    input  wire logic                           reset,
    input  wire logic                           timer_tick,
    input  wire logic [3:0]                     waveform_mode_select,
    input  wire logic [1:0]                     compare_c_output_mode,
    input  wire logic                           counter_clear,
    input  wire logic                           reg_write,
    input  wire logic                           reg_read,
    input  wire logic [7:0]                     reg_addr,
    input  wire logic [tc_limited_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic [2:0]                     flag_write_one,
    input  wire logic [2:0]                     vector_ack,
    output logic [tc_limited_pkg::DATA_W-1:0]   reg_rdata,
    output logic [WIDTH-1:0]                    counter_value,
    output logic [2:0]                          compare_match,
    output logic [2:0]                          match_flags,
    output logic                                forced_match_c,
    output logic [1:0]                          forced_c_mode
);
    // Core state apart from the match pulses and flags, in one record
    typedef struct packed {
        logic [WIDTH-1:0] count;      // Live counter
        logic [WIDTH-1:0] cmp_a;      // Compare value A
        logic [WIDTH-1:0] cmp_b;      // Compare value B
        logic [WIDTH-1:0] cmp_c;      // Compare value C
        logic [7:0]       latch;      // Shared high-byte latch
        logic             block;      // Blank matches on next tick
        logic             forced;     // Forced channel C match pulse
        logic [1:0]       forced_mode;// Output mode seen by the force
        logic [7:0]       rdata;      // Registered read data
    } core_state_t;

    core_state_t state_reg;
    core_state_t state_next;

    // Decodes a waveform setting as one of the non-PWM modes
    function automatic logic is_non_pwm(input logic [3:0] mode);
        return (mode == tc_limited_pkg::MODE_NORMAL) ||
               (mode == tc_limited_pkg::MODE_CTC_A)  ||
               (mode == tc_limited_pkg::MODE_CTC_ALT);
    endfunction

    // Builds a 16-bit word from the latch and a low byte
    function automatic logic [WIDTH-1:0] join_word(input logic [7:0] hi,
                                                   input logic [7:0] lo);
        return WIDTH'({hi, lo});
    endfunction

    logic wr_hit_count;   // Low-byte write to the counter
    logic [2:0] raw_match;

    // Register map on the byte port
    //   control C  bit 5 force strobe,
    //              bits 4 to 0 unused
    //   counter    low byte, high byte
    //   compare A  low byte, high byte
    //   compare B  low byte, high byte
    //   compare C  low byte, high byte
    // Other offsets read zero and drop
    // writes; their owners sit beside us.
    //
    // Word access through the shared latch
    //   Write: the high byte only fills the
    //   latch. The low byte write moves the
    //   latch and the low byte into the word
    //   on one edge, so no comparator ever
    //   sees half of a new value.
    //   Read: a counter low read returns the
    //   low byte and copies the high byte of
    //   the same count into the latch. The
    //   high read returns the latch, so a
    //   carry between reads cannot tear it.
    // One latch serves every word. Code that
    // touches a word from an interrupt must
    // save the latch first; there is no
    // second copy to fall back on.
    // Compare words never change under
    // hardware, so they are read directly.
    //
    // Counter and tick
    //   The count moves only on a tick: up
    //   by one, or to zero when the outside
    //   mode logic asks for a clear at top.
    //   A low byte counter write wins over a
    //   tick in the same cycle, so the new
    //   value is what the next tick sees.
    //   The write also sets the block bit.
    //   It stays until the next tick and
    //   masks that tick on all channels, so
    //   a value written equal to a compare
    //   value does not match at once.
    //   The price: that match is lost, which
    //   is why software should leave a
    //   running counter alone.
    //
    // Match timing
    //   A channel compares the count held at
    //   a tick; its pulse follows on the next
    //   edge and lasts one cycle.
    //   The sticky flag follows the pulse by
    //   one cycle. A clear that meets a set
    //   loses, so no match is dropped by a
    //   late acknowledge.
    //
    // Force strobe on channel C
    //   A control write with bit 5 set, in a
    //   non-PWM mode, gives a one-cycle pulse
    //   after the write and the output mode
    //   of that moment beside it.
    //   The pulse only reaches the forced
    //   outputs: it sets no flag and never
    //   clears the counter, even with
    //   channel C as the top value.
    //   In a PWM mode the write is dropped.
    //   Nothing of the bit is stored, so it
    //   reads back as zero like bits 4 to 0.
    //   The mode decode reads the live mode
    //   input at the write, not a copy.
    //
    // Reset
    //   Synchronous; clears every word, the
    //   latch, the block bit and the pulses.
    //   An access may follow on the first
    //   edge after release.
    //
    // Outputs, all from flip-flops
    //   reg_rdata      held until next read
    //   counter_value  live count
    //   compare_match  pulses, bit 0 is A
    //   match_flags    sticky, bit 0 is A
    //   forced_match_c forced pulse for C
    //   forced_c_mode  mode with the pulse
    //
    // Limitations
    //   Each access is one cycle; a read and
    //   a write in the same cycle are not
    //   supported.
    //   No overflow or capture logic lives
    //   here; those belong to the flag and
    //   capture blocks beside this one.
    //   The latch logic assumes 16-bit words,
    //   so WIDTH should stay at 16.
    //   A forced pulse is not masked by the
    //   block bit; it never drives a flag.

    // Next-state logic: counter, register port and force strobe
    always_comb begin
        state_next        = state_reg;
        state_next.forced = 1'b0;
        state_next.rdata  = state_reg.rdata;
        wr_hit_count      = 1'b0;

        // Each tick advances the count, or zeroes it on counter_clear; the block lasts one tick only
        if (timer_tick) begin
            state_next.block = 1'b0;
            if (counter_clear) begin
                state_next.count = tc_limited_pkg::WORD_RESET;
            end else begin
                state_next.count = state_reg.count + WIDTH'(1);
            end
        end

        if (reg_write) begin
            unique case (reg_addr)
                // high bytes go to the latch
                tc_limited_pkg::OFF_COUNTER_HIGH,
                tc_limited_pkg::OFF_COMPARE_A_HIGH,
                tc_limited_pkg::OFF_COMPARE_B_HIGH,
                tc_limited_pkg::OFF_COMPARE_C_HIGH: begin
                    state_next.latch = reg_wdata;
                end
                tc_limited_pkg::OFF_COUNTER_LOW: begin
                    state_next.count = join_word(state_reg.latch, reg_wdata);
                    wr_hit_count     = 1'b1;
                end
                tc_limited_pkg::OFF_COMPARE_A_LOW: begin
                    state_next.cmp_a = join_word(state_reg.latch, reg_wdata);
                end
                tc_limited_pkg::OFF_COMPARE_B_LOW: begin
                    state_next.cmp_b = join_word(state_reg.latch, reg_wdata);
                end
                tc_limited_pkg::OFF_COMPARE_C_LOW: begin
                    state_next.cmp_c = join_word(state_reg.latch, reg_wdata);
                end
                tc_limited_pkg::OFF_CONTROL_C: begin
                    // force acts as channel C match
                    if (reg_wdata[tc_limited_pkg::FORCE_C_BIT] &&
                        is_non_pwm(waveform_mode_select)) begin
                        state_next.forced      = 1'b1;
                        state_next.forced_mode = compare_c_output_mode;
                    end
                end
                default: begin
                    // Other offsets belong to neighbouring logic
                end
            endcase
        end

        // block the next tick
        // Placed after the tick update so a write in a tick cycle still blocks
        if (wr_hit_count) begin
            state_next.block = 1'b1;
        end

        if (reg_read) begin
            unique case (reg_addr)
                tc_limited_pkg::OFF_COUNTER_LOW: begin
                    state_next.rdata = state_reg.count[7:0];
                    state_next.latch = state_reg.count[15:8];
                end
                // High reads return the latch, as filled by a low read
                tc_limited_pkg::OFF_COUNTER_HIGH: begin
                    state_next.rdata = state_reg.latch;
                end
                // Compare values are never changed by hardware: read direct
                tc_limited_pkg::OFF_COMPARE_A_LOW:  state_next.rdata = state_reg.cmp_a[7:0];
                tc_limited_pkg::OFF_COMPARE_A_HIGH: state_next.rdata = state_reg.cmp_a[15:8];
                tc_limited_pkg::OFF_COMPARE_B_LOW:  state_next.rdata = state_reg.cmp_b[7:0];
                tc_limited_pkg::OFF_COMPARE_B_HIGH: state_next.rdata = state_reg.cmp_b[15:8];
                tc_limited_pkg::OFF_COMPARE_C_LOW:  state_next.rdata = state_reg.cmp_c[7:0];
                tc_limited_pkg::OFF_COMPARE_C_HIGH: state_next.rdata = state_reg.cmp_c[15:8];
                tc_limited_pkg::OFF_CONTROL_C: state_next.rdata = tc_limited_pkg::BYTE_RESET;
                default: state_next.rdata = tc_limited_pkg::BYTE_RESET;
            endcase
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Comparators share one block bit
    // three comparators on every tick
    tc_match_unit #(.WIDTH(WIDTH)) u_match_a (
        .mclk  (mclk),
        .reset (reset),
        .tick  (timer_tick),
        .block (state_reg.block),
        .count (state_reg.count),
        .value (state_reg.cmp_a),
        .match (raw_match[0])
    );
    // Channel B comparator
    tc_match_unit #(.WIDTH(WIDTH)) u_match_b (
        .mclk  (mclk),
        .reset (reset),
        .tick  (timer_tick),
        .block (state_reg.block),
        .count (state_reg.count),
        .value (state_reg.cmp_b),
        .match (raw_match[1])
    );
    // Channel C comparator
    tc_match_unit #(.WIDTH(WIDTH)) u_match_c (
        .mclk  (mclk),
        .reset (reset),
        .tick  (timer_tick),
        .block (state_reg.block),
        .count (state_reg.count),
        .value (state_reg.cmp_c),
        .match (raw_match[2])
    );

    // One sticky flag per channel, A first
    // flags set after match, cleared by ack or one
    // forced pulse never reaches these flags
    tc_flag_bit u_flag_a (
        .mclk  (mclk),
        .reset (reset),
        .set   (raw_match[0]),
        .clear (vector_ack[0] | flag_write_one[0]),
        .flag  (match_flags[0])
    );
    // Channel B flag
    tc_flag_bit u_flag_b (
        .mclk  (mclk),
        .reset (reset),
        .set   (raw_match[1]),
        .clear (vector_ack[1] | flag_write_one[1]),
        .flag  (match_flags[1])
    );
    // Channel C flag
    tc_flag_bit u_flag_c (
        .mclk  (mclk),
        .reset (reset),
        .set   (raw_match[2]),
        .clear (vector_ack[2] | flag_write_one[2]),
        .flag  (match_flags[2])
    );

    // forced match is internal only, no pin
    assign forced_match_c = state_reg.forced;
    assign forced_c_mode  = state_reg.forced_mode;
    assign compare_match  = raw_match;
    assign counter_value  = state_reg.count;
    assign reg_rdata      = state_reg.rdata;
endmodule // tc_limited_core

/* File: logic/tc_limited_pkg.sv */
/*
 * Constants for the reduced 16-bit timer/counter: register offsets, field
 * positions, reset values and waveform mode codes.
 * Assumes a byte-wide internal register port with an 8-bit address.
 */
package tc_limited_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CONTROL_C      = 8'hA2;
    localparam logic [7:0] OFF_COUNTER_LOW    = 8'hA4;
    localparam logic [7:0] OFF_COUNTER_HIGH   = 8'hA5;
    localparam logic [7:0] OFF_COMPARE_A_LOW  = 8'hA8;
    localparam logic [7:0] OFF_COMPARE_A_HIGH = 8'hA9;
    localparam logic [7:0] OFF_COMPARE_B_LOW  = 8'hAA;
    localparam logic [7:0] OFF_COMPARE_B_HIGH = 8'hAB;
    localparam logic [7:0] OFF_COMPARE_C_LOW  = 8'hAC;
    localparam logic [7:0] OFF_COMPARE_C_HIGH = 8'hAD;
    // Control byte field: force strobe position
    localparam int         FORCE_C_BIT        = 5;
    // Reset values
    localparam logic [7:0]  BYTE_RESET        = 8'h00;
    localparam logic [15:0] WORD_RESET        = 16'h0000;
    // Non-PWM waveform mode codes
    localparam logic [3:0] MODE_NORMAL        = 4'h0;
    localparam logic [3:0] MODE_CTC_A         = 4'h4;
    localparam logic [3:0] MODE_CTC_ALT       = 4'hC;
    // Width of the data path
    localparam int         DATA_W             = 8;
endpackage

/* File: logic/tc_match_unit.sv */
/*
 * One compare channel: takes a compare value and raises a match pulse when
 * the counter equals it on a timer clock tick, unless matches are blocked.
 * Assumes the value is already committed whole by the caller.
 */
`timescale 1ns/1ps
module tc_match_unit #(
    parameter int WIDTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             tick,
    input  wire logic             block,
    input  wire logic [WIDTH-1:0] count,
    input  wire logic [WIDTH-1:0] value,
    output logic                  match
);
    // Registered match pulse
    typedef struct packed {
        logic match;
    } match_state_t;

    match_state_t state_reg;
    match_state_t state_next;

    // Compare on every tick; a write to the counter blanks one tick
    always_comb begin
        state_next       = state_reg;
        state_next.match = tick && !block && (count == value);
    end

    // State register
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign match = state_reg.match;
endmodule // tc_match_unit

/* File: test/tc_limited_core_test.sv */
/* Self-checking bench for tc_limited_core.
   Assumes the register port contract: one-cycle strobes, read data next cycle. */
`timescale 1ns/1ps
module tc_limited_core_test;
    logic        mclk, reset, timer_tick, counter_clear, reg_write, reg_read, forced_match_c;
    logic [3:0]  waveform_mode_select;
    logic [1:0]  compare_c_output_mode, forced_c_mode;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [2:0]  flag_write_one, vector_ack, compare_match, match_flags;
    logic [15:0] counter_value, v;
    int          bad_count = 0, cmp_count = 0, seed = 39495;
    // Byte offsets of the counter and compare registers, low byte first
    logic [7:0]  offs [8] = '{8'hA4, 8'hA5, 8'hA8, 8'hA9, 8'hAA, 8'hAB, 8'hAC, 8'hAD};

    tc_limited_core dut (.mclk(mclk), .reset(reset), .timer_tick(timer_tick),
        .waveform_mode_select(waveform_mode_select),
        .compare_c_output_mode(compare_c_output_mode), .counter_clear(counter_clear),
        .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .flag_write_one(flag_write_one), .vector_ack(vector_ack),
        .reg_rdata(reg_rdata), .counter_value(counter_value), .compare_match(compare_match),
        .match_flags(match_flags), .forced_match_c(forced_match_c),
        .forced_c_mode(forced_c_mode));

    // 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    function automatic logic npwm(input logic [3:0] m);
        return m == tc_limited_pkg::MODE_NORMAL || m == tc_limited_pkg::MODE_CTC_A
            || m == tc_limited_pkg::MODE_CTC_ALT;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Each task raises its strobe and lowers the others 1 ns after an edge;
    // a strobe left up by the last call is never assigned twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {reg_write, reg_read, timer_tick} = 3'h4;
        reg_addr = a;
        reg_wdata = d;
        @(posedge mclk);
        #1;
    endtask

    // High byte goes to the shared latch first, low byte commits both
    task automatic wr16(input logic [7:0] hi, input logic [15:0] d);
        wr(hi, d[15:8]);
        wr(hi - 8'h01, d[7:0]);
    endtask

    task automatic rd(input logic [7:0] a);
        {reg_write, reg_read, timer_tick} = 3'h2;
        reg_addr = a;
        @(posedge mclk);
        #1;
    endtask

    task automatic tick;
        {reg_write, reg_read, timer_tick} = 3'h1;
        @(posedge mclk);
        #1;
    endtask

    // An edge with every strobe low
    task automatic idle;
        {reg_write, reg_read, timer_tick} = 3'h0;
        @(posedge mclk);
        #1;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        results();
    end

    initial begin
        {reset, timer_tick, counter_clear, reg_write, reg_read} = 5'h10;
        {waveform_mode_select, compare_c_output_mode, flag_write_one, vector_ack} = 12'h000;
        {reg_addr, reg_wdata} = 16'h0000;
        repeat (16) @(posedge mclk);
        #1 reset = 1'b0;
        foreach (offs[i]) begin
            rd(offs[i]);
            check(reg_rdata, 16'h0000);
        end
        // Counter goes in and out whole through the latch
        v = 16'($random(seed));
        // counter written only while no tick runs
        wr16(tc_limited_pkg::OFF_COUNTER_HIGH, v);
        check(counter_value, v);
        rd(tc_limited_pkg::OFF_COUNTER_LOW);
        check(reg_rdata, v[7:0]);
        rd(tc_limited_pkg::OFF_COUNTER_HIGH);
        check(reg_rdata, v[15:8]);
        // A compare high write lands in the same latch
        wr(tc_limited_pkg::OFF_COMPARE_A_HIGH, 8'h5A);
        rd(tc_limited_pkg::OFF_COUNTER_HIGH);
        check(reg_rdata, 16'h005A);
        // Three channels one apart; the first tick after the write is blocked
        v = {1'b0, 15'($random(seed))} + 16'h0010;
        wr16(tc_limited_pkg::OFF_COMPARE_A_HIGH, v);
        wr16(tc_limited_pkg::OFF_COMPARE_B_HIGH, v + 16'h0001);
        wr16(tc_limited_pkg::OFF_COMPARE_C_HIGH, v + 16'h0002);
        wr16(tc_limited_pkg::OFF_COUNTER_HIGH, v);
        tick();
        check(compare_match, 16'h0000);
        tick();
        check(compare_match, 16'h0002);
        tick();
        check(compare_match, 16'h0004);
        check(match_flags, 16'h0002);
        // B cleared by a written one; the ack for C meets its set and loses
        flag_write_one = 3'b010;
        vector_ack = 3'b100;
        idle();
        check(match_flags, 16'h0004);
        flag_write_one = 3'b000;
        idle();
        vector_ack = 3'b000;
        check(match_flags, 16'h0000);
        wr16(tc_limited_pkg::OFF_COUNTER_HIGH, v - 16'h0001);
        tick();
        tick();
        check(compare_match, 16'h0001);
        // Force strobe in every mode
        for (int m = 0; m < 16; m++) begin
            waveform_mode_select = m[3:0];
            compare_c_output_mode = 2'($random(seed));
            wr(tc_limited_pkg::OFF_CONTROL_C, {3'b001, 5'($random(seed))});
            check(forced_match_c, npwm(m[3:0]));
            if (npwm(m[3:0])) check(forced_c_mode, compare_c_output_mode);
            check(counter_value, v + 16'h0001);
            check(match_flags, 16'h0001);
        end
        rd(tc_limited_pkg::OFF_CONTROL_C);
        check(reg_rdata, 16'h0000);
        // Mid-run reset while the count and flag A are live
        reset = 1'b1;
        idle();
        reset = 1'b0;
        check(counter_value, 16'h0000);
        check(match_flags, 16'h0000);
        tick();
        check(counter_value, 16'h0001);
        counter_clear = 1'b1;
        tick();
        counter_clear = 1'b0;
        check(counter_value, 16'h0000);
        results();
    end
endmodule // tc_limited_core_test

/* File: test/tc_limited_monitor.sv */
/* Port checker for tc_limited_core.
   Assumes one clock mclk and a synchronous active-high reset. */
`timescale 1ns/1ps
module tc_limited_monitor #(
    parameter int WIDTH = 16
) (
    input wire logic             mclk,
    input wire logic             reset,
    input wire logic             timer_tick,
    input wire logic [3:0]       waveform_mode_select,
    input wire logic [1:0]       compare_c_output_mode,
    input wire logic             reg_write,
    input wire logic             reg_read,
    input wire logic [7:0]       reg_addr,
    input wire logic [7:0]       reg_wdata,
    input wire logic [2:0]       flag_write_one,
    input wire logic [2:0]       vector_ack,
    input wire logic [7:0]       reg_rdata,
    input wire logic [WIDTH-1:0] counter_value,
    input wire logic [2:0]       compare_match,
    input wire logic [2:0]       match_flags,
    input wire logic             forced_match_c,
    input wire logic [1:0]       forced_c_mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // Force write as seen on the register port
    wire       frc = reg_write && reg_addr == tc_limited_pkg::OFF_CONTROL_C
                     && reg_wdata[tc_limited_pkg::FORCE_C_BIT];
    // Non-PWM mode codes
    wire       npwm = waveform_mode_select == tc_limited_pkg::MODE_NORMAL
                     || waveform_mode_select == tc_limited_pkg::MODE_CTC_A
                     || waveform_mode_select == tc_limited_pkg::MODE_CTC_ALT;
    // Any flag clear request
    wire [2:0] clr = flag_write_one | vector_ack;
    // Low counter byte, so sampled functions see a plain signal
    wire [7:0] cnt_lo = counter_value[7:0];

    a_force_pwm_ignored: assert property (frc && !npwm |=> !forced_match_c)
        else $error("force honoured in a PWM mode");
    a_force_acts_now: assert property (frc && npwm |=> forced_match_c)
        else $error("force did not act at once");
    a_force_mode_copy: assert property (frc && npwm |=> forced_c_mode == $past(compare_c_output_mode))
        else $error("forced mode not captured");
    a_force_has_cause: assert property (forced_match_c |-> $past(frc))
        else $error("forced pulse without a strobe");
    a_force_no_clear: assert property (frc && !timer_tick |=> $stable(counter_value))
        else $error("force moved the counter");
    a_write_blocks_match: assert property ($past(reg_write && reg_addr == tc_limited_pkg::OFF_COUNTER_LOW) && timer_tick |=> compare_match == 3'h0)
        else $error("match after counter write");
    a_match_needs_tick: assert property (compare_match != 3'h0 |-> $past(timer_tick))
        else $error("match without tick");
    a_flag_follows_match: assert property (compare_match != 3'h0 |=>
        (match_flags & $past(compare_match)) == $past(compare_match))
        else $error("flag not set after match");
    a_flag_clear_one: assert property (clr != 3'h0 |=>
        (match_flags & $past(clr) & ~$past(compare_match)) == 3'h0)
        else $error("flag not cleared");
    a_counter_read_low: assert property (reg_read && reg_addr == tc_limited_pkg::OFF_COUNTER_LOW |=> reg_rdata == $past(cnt_lo))
        else $error("counter low read wrong");
    a_force_reads_zero: assert property (reg_read && reg_addr == tc_limited_pkg::OFF_CONTROL_C |=> !reg_rdata[5])
        else $error("force bit read as one");
    a_reset_zeroes: assert property (disable iff (1'b0) reset |=> counter_value == 16'h0000 && match_flags == 3'h0)
        else $error("state not zero after reset");
endmodule // tc_limited_monitor

bind tc_limited_core tc_limited_monitor #(.WIDTH(WIDTH)) u_monitor (.*);
